// ===== hdl/bit_flag_unit.sv
`include "bit_shift_flag_map.svh"

module bit_flag_unit
  import bit_shift_flag_pkg::*;
(
  exec_if.bit_side bus
);

  // ************************************************************
  // single bit selection and status bit writes
  // ************************************************************
  wire [7:0] b_mask = bit_mask(bus.bit_sel);
  wire [7:0] f_mask = bit_mask(bus.flag_sel);
  wire t_flag = bus.flags_in[`FLAG_T];
  wire is_io_set = (bus.op == op_io_bit_set);
  wire is_io_clr = (bus.op == op_io_bit_clear);
  wire is_to_t = (bus.op == op_bit_to_transfer_flag);
  wire is_from_t = (bus.op == op_transfer_flag_to_bit);
  wire is_fset = (bus.op == op_status_bit_set);
  wire is_fclr = (bus.op == op_status_bit_clear);
  wire src_bit = |(bus.operand & b_mask);

  assign bus.bf_io_data = is_io_set ? (bus.io_data | b_mask) :
                          (bus.io_data & ~b_mask);
  assign bus.bf_result = t_flag ? (bus.operand | b_mask) :
                         (bus.operand & ~b_mask);
  assign bus.bf_hit = is_io_set | is_io_clr | is_to_t | is_from_t |
                      is_fset | is_fclr;

  // each write touches one flag only
  always_comb begin
    bus.bf_flags = bus.flags_in;
    if (is_to_t) begin
      bus.bf_flags[`FLAG_T] = src_bit;
    end
    if (is_fset) begin
      bus.bf_flags = bus.flags_in | f_mask;
    end
    if (is_fclr) begin
      bus.bf_flags = bus.flags_in & ~f_mask;
    end
  end

endmodule

// ===== hdl/bit_shift_flag_exec_unit.sv
// Contract
// - rotate left through carry puts carry in bit 0, shifts up, bit 7 to carry, sets Z C N V H in one clock.
// - rotate right through carry puts carry in bit 7, shifts down, bit 0 to carry, sets Z C N V but not H in one clock.
// - setting an I/O bit forces the chosen bit of the addressed I/O register to one in one clock, flags kept.
// - clearing an I/O bit forces the chosen bit of the addressed I/O register to zero in one clock, flags kept.
// - bit store copies the chosen source bit into the transfer flag in one clock, no other flag changes.
// - bit load copies the transfer flag into the chosen destination bit in one clock, flags kept.
// - overflow set writes one to the overflow flag in one clock and nothing else.
// - overflow clear writes zero to the overflow flag in one clock and nothing else.
// - half-carry set writes one to the half-carry flag in one clock and nothing else.
// - half-carry clear writes zero to the half-carry flag in one clock and nothing else.
// - sign set writes one to the signed test flag in one clock and nothing else.
// - sign clear writes zero to the signed test flag in one clock and nothing else.
// - cycle counts with data memory hold for internal memory only; external accesses wait for the bus.
// - an access to internal SRAM adds one extra clock to the instruction.
`include "bit_shift_flag_map.svh"

module bit_shift_flag_exec_unit
  import bit_shift_flag_pkg::*;
#(
  parameter int IO_ADDR_W = 6
)
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire op_t op_code_i,
  input wire logic [7:0] operand_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [2:0] flag_sel_i,
  input wire logic [IO_ADDR_W-1:0] io_addr_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic mem_access_i,
  input wire logic ext_mem_i,
  input wire logic ext_ready_i,
  output logic op_ready_o,
  output logic [7:0] result_o,
  output logic result_we_o,
  output logic [IO_ADDR_W-1:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_we_o,
  output logic [7:0] status_flags_word_o,
  output logic done_o
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // release goes through two flops so no register leaves reset on a
  // different edge; assertion of reset stays asynchronous
  wire rst_n = rst_sync_reg;

  // ************************************************************
  // execution units
  // ************************************************************
  exec_if ex ();
  logic [7:0] flags_reg;

  assign ex.op = op_code_i;
  assign ex.operand = operand_i;
  assign ex.io_data = io_rdata_i;
  assign ex.bit_sel = bit_sel_i;
  assign ex.flag_sel = flag_sel_i;
  assign ex.flags_in = flags_reg;

  rotate_shift_unit u_shift (
    .bus(ex.shift_side)
  );

  bit_flag_unit u_bit (
    .bus(ex.bit_side)
  );

  // ************************************************************
  // sequencing
  // ************************************************************
  state_t state_reg;
  state_t state_next;

  wire take = op_valid_i & (state_reg == st_idle);
  wire is_io = (op_code_i == op_io_bit_set) |
               (op_code_i == op_io_bit_clear);
  wire writes_rd = ex.sh_hit | (op_code_i == op_transfer_flag_to_bit);
  wire uses_sram = mem_access_i & ~ext_mem_i;
  wire uses_ext = mem_access_i & ext_mem_i;
  // an op with no memory access retires in its first clock
  wire done_next = (take & ~mem_access_i) |
                   (state_reg == st_sram) |
                   ((state_reg == st_ext) & ext_ready_i);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_idle: begin
        if (take & uses_sram) begin
          state_next = st_sram;
        end else if (take & uses_ext) begin
          state_next = st_ext;
        end
      end
      st_sram: begin
        state_next = st_idle;
      end
      st_ext: begin
        // external bus sets the pace, no fixed count applies
        if (ext_ready_i) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  assign op_ready_o = (state_reg == st_idle);

  // ************************************************************
  // committed state
  // ************************************************************
  wire [7:0] flags_next = ex.sh_hit ? ex.sh_flags :
                          ex.bf_hit ? ex.bf_flags : flags_reg;
  wire [7:0] result_next = ex.sh_hit ? ex.sh_result : ex.bf_result;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_idle;
      done_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_o <= done_next;
    end
  end

  // flags, data and I/O write commit on the taking edge
  // memory access only delays done and ready, never the data
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `FLAGS_RESET;
      result_o <= `DATA_RESET;
      result_we_o <= 1'b0;
      io_addr_o <= IO_ADDR_W'(`IO_ADDR_RESET);
      io_wdata_o <= `DATA_RESET;
      io_we_o <= 1'b0;
    end else begin
      result_we_o <= take & writes_rd;
      io_we_o <= take & is_io;
      if (take) begin
        flags_reg <= flags_next;
        result_o <= result_next;
        io_addr_o <= io_addr_i;
        io_wdata_o <= ex.bf_io_data;
      end
    end
  end

  assign status_flags_word_o = flags_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // datapath checks
  // ************************************************************
  wire t_rot_l = take & (op_code_i == op_rotate_left_carry);
  wire t_rot_r = take & (op_code_i == op_rotate_right_carry);
  wire t_ashr = take & (op_code_i == op_arith_shift_right);
  wire t_shift = t_rot_l | t_rot_r | t_ashr;
  wire t_swap = take & (op_code_i == op_nibble_swap);
  wire t_io = take & is_io;
  wire t_to_t = take & (op_code_i == op_bit_to_transfer_flag);
  wire t_from_t = take & (op_code_i == op_transfer_flag_to_bit);
  wire t_fset = take & (op_code_i == op_status_bit_set);
  wire t_fclr = take & (op_code_i == op_status_bit_clear);

  a_rotate_left: assert property (t_rot_l |=>
    result_o == {$past(operand_i[6:0]), $past(flags_reg[`FLAG_C])} &&
    flags_reg[`FLAG_C] == $past(operand_i[7]) &&
    flags_reg[`FLAG_H] == $past(operand_i[3]))
    else $error("rotate left result or flags wrong");

  a_rotate_right: assert property (t_rot_r |=>
    result_o == {$past(flags_reg[`FLAG_C]), $past(operand_i[7:1])} &&
    flags_reg[`FLAG_C] == $past(operand_i[0]) &&
    flags_reg[`FLAG_H] == $past(flags_reg[`FLAG_H]) &&
    flags_reg[`FLAG_V] == (result_o[7] ^ flags_reg[`FLAG_C]))
    else $error("rotate right result or flags wrong");

  a_io_bit_write: assert property (t_io |=> io_we_o &&
    io_addr_o == $past(io_addr_i) &&
    io_wdata_o[$past(bit_sel_i)] ==
      ($past(op_code_i) == op_io_bit_set) &&
    $stable(flags_reg) ##1 !io_we_o || $past(take))
    else $error("io bit write wrong");

  a_transfer_store: assert property (t_to_t |=>
    flags_reg[`FLAG_T] == $past(operand_i[bit_sel_i]) &&
    (flags_reg & 8'hBF) == ($past(flags_reg) & 8'hBF))
    else $error("bit store wrong");

  a_transfer_load: assert property (t_from_t |=> result_we_o &&
    result_o[$past(bit_sel_i)] == $past(flags_reg[`FLAG_T]) &&
    $stable(flags_reg))
    else $error("bit load wrong");

  a_flag_set_one: assert property (t_fset |=>
    flags_reg == ($past(flags_reg) | bit_mask($past(flag_sel_i))))
    else $error("flag set touched wrong bits");

  a_flag_clr_one: assert property (t_fclr |=>
    flags_reg == ($past(flags_reg) & ~bit_mask($past(flag_sel_i))))
    else $error("flag clear touched wrong bits");

  a_arith_shift: assert property (t_ashr |=>
    result_o == {$past(operand_i[7]), $past(operand_i[7:1])} &&
    flags_reg[`FLAG_H] == $past(flags_reg[`FLAG_H]) &&
    flags_reg[`FLAG_C] == $past(operand_i[0]) &&
    flags_reg[`FLAG_Z] == (result_o == 8'h00))
    else $error("arith shift wrong");

  a_swap_nibbles: assert property (t_swap |=>
    result_o == {$past(operand_i[3:0]), $past(operand_i[7:4])} &&
    $stable(flags_reg))
    else $error("nibble swap wrong");

  // rotates and the shift share N, Z and V; S, T and I never move
  a_shift_common: assert property (t_shift |=>
    flags_reg[`FLAG_N] == result_o[7] &&
    flags_reg[`FLAG_Z] == (result_o == 8'h00) &&
    flags_reg[`FLAG_V] == (result_o[7] ^ flags_reg[`FLAG_C]) &&
    (flags_reg & 8'hD0) == ($past(flags_reg) & 8'hD0))
    else $error("shift flags wrong");

  // read-modify-write: only the chosen bit may move
  a_io_other_bits: assert property (t_io |=>
    (io_wdata_o & ~bit_mask($past(bit_sel_i))) ==
      ($past(io_rdata_i) & ~bit_mask($past(bit_sel_i))))
    else $error("io write disturbed other bits");

  a_load_other_bits: assert property (t_from_t |=>
    (result_o & ~bit_mask($past(bit_sel_i))) ==
      ($past(operand_i) & ~bit_mask($past(bit_sel_i))))
    else $error("bit load disturbed other bits");

  a_none_keeps: assert property (take && op_code_i == op_none |=>
    $stable(flags_reg) && !result_we_o && !io_we_o)
    else $error("empty op changed state");

  // ************************************************************
  // timing checks
  // ************************************************************
  a_sram_extra: assert property (take && uses_sram |=>
    !done_o && !op_ready_o ##1 done_o && op_ready_o)
    else $error("sram access not one clock longer");

  a_plain_single: assert property (take && !mem_access_i |=>
    done_o && op_ready_o)
    else $error("plain op not done in one clock");

  a_ext_hold: assert property (state_reg == st_ext && !ext_ready_i |=>
    !done_o && state_reg == st_ext)
    else $error("external access ended without ready");

  a_ext_release: assert property (
    state_reg == st_ext && ext_ready_i |=> done_o && op_ready_o)
    else $error("external access not retired after ready");

  // a busy unit must neither commit nor pulse for a request it refused
  a_busy_refused: assert property (
    op_valid_i && !op_ready_o |=>
    $stable(flags_reg) && $stable(result_o) && !result_we_o && !io_we_o)
    else $error("request taken while busy");

  a_hold_until_take: assert property (!take |=>
    $stable(flags_reg) && $stable(result_o) && $stable(io_wdata_o) &&
    !result_we_o && !io_we_o)
    else $error("outputs moved without a take");

  c_rotate_seen: cover property (t_rot_l ##1 done_o);
  c_sram_seen: cover property (take && uses_sram ##2 done_o);
  c_ext_wait: cover property (take && uses_ext ##1 !ext_ready_i [*2]
    ##1 ext_ready_i ##1 done_o);
  c_io_back: cover property (t_io ##1 t_io);
  c_swap_seen: cover property (t_swap ##1 result_we_o);

endmodule

// ===== hdl/rotate_shift_unit.sv
`include "bit_shift_flag_map.svh"

module rotate_shift_unit
  import bit_shift_flag_pkg::*;
(
  exec_if.shift_side bus
);

  // ************************************************************
  // shifter datapath
  // ************************************************************
  wire [7:0] d = bus.operand;
  wire c_in = bus.flags_in[`FLAG_C];
  wire is_rot_l = (bus.op == op_rotate_left_carry);
  wire is_rot_r = (bus.op == op_rotate_right_carry);
  wire is_ashr = (bus.op == op_arith_shift_right);
  wire is_swap = (bus.op == op_nibble_swap);
  wire [7:0] rot_l_res = {d[6:0], c_in};
  wire [7:0] rot_r_res = {c_in, d[7:1]};
  wire [7:0] ashr_res = {d[7], d[7:1]};
  wire [7:0] swap_res = {d[3:0], d[7:4]};
  wire [7:0] res = is_rot_l ? rot_l_res :
                   is_rot_r ? rot_r_res :
                   is_ashr ? ashr_res : swap_res;
  wire c_out = is_rot_l ? d[7] : d[0];
  wire n_out = res[7];

  assign bus.sh_result = res;
  assign bus.sh_hit = is_rot_l | is_rot_r | is_ashr | is_swap;

  // swap keeps every flag, so the merge only runs for the shifts
  always_comb begin
    bus.sh_flags = bus.flags_in;
    if (is_rot_l | is_rot_r | is_ashr) begin
      bus.sh_flags[`FLAG_C] = c_out;
      bus.sh_flags[`FLAG_Z] = (res == 8'h00);
      bus.sh_flags[`FLAG_N] = n_out;
      bus.sh_flags[`FLAG_V] = n_out ^ c_out;
    end
    if (is_rot_l) begin
      bus.sh_flags[`FLAG_H] = d[3];
    end
  end

endmodule

// ===== include/bit_shift_flag_map.svh
`ifndef BIT_SHIFT_FLAG_MAP_SVH
`define BIT_SHIFT_FLAG_MAP_SVH

// ************************************************************
// status word bit positions
// ************************************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ************************************************************
// reset values and timing counts
// ************************************************************
`define FLAGS_RESET 8'h00
`define DATA_RESET 8'h00
`define IO_ADDR_RESET 6'h00
`define BASE_CYCLES 1
`define SRAM_EXTRA_CYCLES 1

`endif

// ===== include/bit_shift_flag_pkg.sv
package bit_shift_flag_pkg;

  // ************************************************************
  // operation codes presented by instruction decode
  // ************************************************************
  typedef enum logic [3:0] {
    op_none                  = 4'h0,
    op_rotate_left_carry     = 4'h1,
    op_rotate_right_carry    = 4'h2,
    op_arith_shift_right     = 4'h3,
    op_nibble_swap           = 4'h4,
    op_status_bit_set        = 4'h5,
    op_status_bit_clear      = 4'h6,
    op_io_bit_set            = 4'h7,
    op_io_bit_clear          = 4'h8,
    op_bit_to_transfer_flag  = 4'h9,
    op_transfer_flag_to_bit  = 4'hA
  } op_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_sram = 3'h2,
    st_ext  = 3'h4
  } state_t;

  // one-hot select of a bit within a byte
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

endpackage

// ===== include/exec_if.sv
interface exec_if;
  import bit_shift_flag_pkg::*;
  op_t op;
  logic [7:0] operand;
  logic [7:0] io_data;
  logic [2:0] bit_sel;
  logic [2:0] flag_sel;
  logic [7:0] flags_in;
  logic [7:0] sh_result;
  logic [7:0] sh_flags;
  logic sh_hit;
  logic [7:0] bf_result;
  logic [7:0] bf_flags;
  logic [7:0] bf_io_data;
  logic bf_hit;

  modport core (output op, operand, io_data, bit_sel, flag_sel, flags_in,
                input sh_result, sh_flags, sh_hit,
                input bf_result, bf_flags, bf_io_data, bf_hit);
  modport shift_side (input op, operand, flags_in,
                      output sh_result, sh_flags, sh_hit);
  modport bit_side (input op, operand, io_data, bit_sel, flag_sel, flags_in,
                    output bf_result, bf_flags, bf_io_data, bf_hit);
endinterface

// ===== verification/testbench.sv
`include "bit_shift_flag_map.svh"

module testbench
  import bit_shift_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // stimulus and design signals
  // ************************************************************
  logic sys_clk_i;
  logic rst_b_i;
  logic op_valid_i;
  op_t op_code_i;
  logic [7:0] operand_i;
  logic [2:0] bit_sel_i;
  logic [2:0] flag_sel_i;
  logic [5:0] io_addr_i;
  logic [7:0] io_rdata_i;
  logic mem_access_i;
  logic ext_mem_i;
  logic ext_ready_i;
  logic op_ready_o;
  logic [7:0] result_o;
  logic result_we_o;
  logic [5:0] io_addr_o;
  logic [7:0] io_wdata_o;
  logic io_we_o;
  logic [7:0] status_flags_word_o;
  logic done_o;
  int err_total;
  int comparisons;
  logic [31:0] rnd;
  logic [7:0] mflags;
  logic [7:0] tbl [4];

  bit_shift_flag_exec_unit #(.IO_ADDR_W(6)) bit_shift_flag_exec_unit_inst (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .op_valid_i(op_valid_i),
    .op_code_i(op_code_i),
    .operand_i(operand_i),
    .bit_sel_i(bit_sel_i),
    .flag_sel_i(flag_sel_i),
    .io_addr_i(io_addr_i),
    .io_rdata_i(io_rdata_i),
    .mem_access_i(mem_access_i),
    .ext_mem_i(ext_mem_i),
    .ext_ready_i(ext_ready_i),
    .op_ready_o(op_ready_o),
    .result_o(result_o),
    .result_we_o(result_we_o),
    .io_addr_o(io_addr_o),
    .io_wdata_o(io_wdata_o),
    .io_we_o(io_we_o),
    .status_flags_word_o(status_flags_word_o),
    .done_o(done_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // ************************************************************
  // compare and report
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk1(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ************************************************************
  // reference model: 8-bit mirror of the flag word, updated per take
  // ************************************************************
  task automatic model(input op_t op, output logic [7:0] r,
                       output logic rwe, output logic iwe);
    logic c;
    logic [7:0] m;
    c = mflags[`FLAG_C];
    m = 8'h01 << bit_sel_i;
    r = operand_i;
    rwe = 1'b0;
    iwe = 1'b0;
    case (op)
      op_rotate_left_carry: begin
        r = {operand_i[6:0], c};
        mflags[`FLAG_C] = operand_i[7];
        mflags[`FLAG_H] = operand_i[3];
      end
      op_rotate_right_carry: begin
        r = {c, operand_i[7:1]};
        mflags[`FLAG_C] = operand_i[0];
      end
      op_arith_shift_right: begin
        r = {operand_i[7], operand_i[7:1]};
        mflags[`FLAG_C] = operand_i[0];
      end
      op_nibble_swap: r = {operand_i[3:0], operand_i[7:4]};
      op_status_bit_set: mflags[flag_sel_i] = 1'b1;
      op_status_bit_clear: mflags[flag_sel_i] = 1'b0;
      op_io_bit_set: r = io_rdata_i | m;
      op_io_bit_clear: r = io_rdata_i & ~m;
      op_bit_to_transfer_flag: mflags[`FLAG_T] = operand_i[bit_sel_i];
      op_transfer_flag_to_bit: r[bit_sel_i] = mflags[`FLAG_T];
      default: r = operand_i;
    endcase
    if (op inside {op_rotate_left_carry, op_rotate_right_carry,
                   op_arith_shift_right}) begin
      mflags[`FLAG_N] = r[7];
      mflags[`FLAG_Z] = (r == 8'h00);
      mflags[`FLAG_V] = r[7] ^ mflags[`FLAG_C];
    end
    rwe = op inside {op_rotate_left_carry, op_rotate_right_carry,
                     op_arith_shift_right, op_nibble_swap,
                     op_transfer_flag_to_bit};
    iwe = op inside {op_io_bit_set, op_io_bit_clear};
  endtask

  // ************************************************************
  // one request; mode 0 plain, 1 internal sram, 2 external bus
  // ************************************************************
  task automatic run_op(input op_t op, input logic [7:0] d,
                        input logic [2:0] b, input logic [2:0] f,
                        input int mode);
    logic [7:0] r;
    logic rwe;
    logic iwe;
    rnd = lfsr(rnd);
    op_valid_i = 1'b1;
    op_code_i = op;
    operand_i = d;
    bit_sel_i = b;
    flag_sel_i = f;
    io_addr_i = rnd[5:0];
    io_rdata_i = rnd[15:8];
    mem_access_i = (mode != 0);
    ext_mem_i = (mode == 2);
    ext_ready_i = 1'b0;
    chk1(op_ready_o, 1'b1, "ready before take");
    model(op, r, rwe, iwe);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk1(result_we_o, rwe, "result write pulse");
    chk1(io_we_o, iwe, "io write pulse");
    if (rwe)
      chk8(result_o, r, "result");
    if (iwe) begin
      chk8(io_wdata_o, r, "io data");
      chk8({2'h0, io_addr_o}, {2'h0, io_addr_i}, "io address");
    end
    chk8(status_flags_word_o, mflags, "flags");
    chk1(done_o, mode == 0, "done after one clock");
    chk1(op_ready_o, mode == 0, "ready after take");
    if (mode != 0) begin
      // a request while busy must be ignored
      op_code_i = mflags[7] ? op_status_bit_clear : op_status_bit_set;
      flag_sel_i = 3'h7;
      if (mode == 2) begin
        repeat (3) begin
          @(negedge sys_clk_i);
          chk1(op_ready_o, 1'b0, "waiting on bus");
          chk1(done_o, 1'b0, "early done");
        end
        ext_ready_i = 1'b1;
      end
      @(negedge sys_clk_i);
      chk1(done_o, 1'b1, "memory done");
      chk1(op_ready_o, 1'b1, "ready again");
      chk8(status_flags_word_o, mflags, "refused op kept flags");
      op_valid_i = 1'b0;
      ext_ready_i = 1'b0;
      mem_access_i = 1'b0;
      ext_mem_i = 1'b0;
      @(negedge sys_clk_i);
    end
  endtask

  task automatic idle();
    op_valid_i = 1'b0;
    @(negedge sys_clk_i);
    chk1(done_o, 1'b0, "done one cycle");
    chk1(result_we_o, 1'b0, "result pulse one cycle");
    chk1(io_we_o, 1'b0, "io pulse one cycle");
  endtask

  task automatic do_reset();
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk8(status_flags_word_o, 8'h00, "flags in reset");
    chk1(op_ready_o, 1'b1, "ready in reset");
    chk1(done_o, 1'b0, "done in reset");
    mflags = 8'h00;
    rst_b_i = 1'b1;
    // two flops of reset release, then one spare cycle
    repeat (3) @(negedge sys_clk_i);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = op_none;
    operand_i = 8'h00;
    bit_sel_i = 3'h0;
    flag_sel_i = 3'h0;
    io_addr_i = 6'h00;
    io_rdata_i = 8'h00;
    mem_access_i = 1'b0;
    ext_mem_i = 1'b0;
    ext_ready_i = 1'b0;
    err_total = 0;
    comparisons = 0;
    rnd = 32'h0000_15BE;
    tbl = '{8'h00, 8'h80, 8'h01, 8'hFF};
    do_reset();
    @(negedge sys_clk_i);
    for (int f = 0; f < 8; f++) begin
      run_op(op_status_bit_set, 8'h00, 3'h0, 3'(f), 0);
      run_op(op_status_bit_set, 8'h00, 3'h0, 3'(7 - f), 0);
      run_op(op_status_bit_clear, 8'h00, 3'h0, 3'(f), 0);
    end
    for (int i = 0; i < 24; i++) begin
      run_op(i[0] ? op_status_bit_set : op_status_bit_clear, 8'h00,
             3'h0, 3'h0, 0);
      run_op(op_t'(4'(i % 3 + 1)), tbl[(i / 3) % 4], 3'h0, 3'h0, 0);
    end
    for (int i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      run_op(op_t'(rnd[3:0] % 4'hB), rnd[15:8], rnd[18:16],
             rnd[21:19], 0);
    end
    idle();
    run_op(op_rotate_left_carry, 8'hA5, 3'h0, 3'h0, 1);
    run_op(op_io_bit_set, 8'h3C, 3'h5, 3'h0, 2);
    run_op(op_bit_to_transfer_flag, 8'h40, 3'h6, 3'h0, 1);
    run_op(op_none, 8'h5A, 3'h1, 3'h2, 0);
    idle();
    run_op(op_status_bit_set, 8'h00, 3'h0, 3'h3, 0);
    idle();
    do_reset();
    @(negedge sys_clk_i);
    run_op(op_transfer_flag_to_bit, 8'hFF, 3'h7, 3'h0, 0);
    idle();
    summarize();
  end

  // a hang beyond the expected length counts as a failure
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    err_total++;
    summarize();
  end
endmodule
